/* core/rxd_pkg.sv */
package rxd_pkg;
  localparam int BAR_W       = 8;
  localparam int BEATS_W     = 11;
  localparam int DEPTH_DFLT  = 16;
  localparam int DATA_W_DFLT = 64;
  localparam logic [15:0] DEV_CTRL_RST = 16'h0000;
  localparam logic [1:0]  SPL_SCALE_RST = 2'h0;
  localparam logic [7:0]  SPL_VALUE_RST = 8'h00;
  localparam int SPL_SCALE_LSB = 8;
  // capability payload codes 128/256/512/1024 bytes
  localparam logic [2:0] MPS_128  = 3'h0;
  localparam logic [2:0] MPS_256  = 3'h1;
  localparam logic [2:0] MPS_512  = 3'h2;
  localparam logic [2:0] MPS_1024 = 3'h3;

  typedef enum logic [4:0] {
    K_MEM     = 5'h00,
    K_IO      = 5'h01,
    K_ATOMIC  = 5'h02,
    K_MEM_LK  = 5'h03,
    K_CFG0    = 5'h04,
    K_CFG1    = 5'h05,
    K_CPL     = 5'h06,
    K_SSPL    = 5'h07,
    K_PME     = 5'h08,
    K_TO_ACK  = 5'h09,
    K_ASNAK   = 5'h0A,
    K_TURNOFF = 5'h0B,
    K_UNLOCK  = 5'h0C,
    K_INTX    = 5'h0D,
    K_ERRMSG  = 5'h0E,
    K_VDM     = 5'h0F,
    K_HOTPLUG = 5'h10
  } rxd_kind_e;

  typedef enum logic [2:0] {
    D_PRESENT = 3'h0,
    D_CONSUME = 3'h1,
    D_UR      = 3'h2,
    D_UC      = 3'h3,
    D_FATAL   = 3'h4,
    D_DROP    = 3'h5,
    D_IGNORE  = 3'h6
  } rxd_disp_e;

  typedef enum logic [2:0] {
    O_IDLE = 3'b001,
    O_PKT  = 3'b010,
    O_PAD  = 3'b100
  } rxd_ostate_e;
endpackage : rxd_pkg

/* core/rxd_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module rxd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_clk_en,
  input  wire logic         i_flush,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rd_q];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_data;
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (i_clk_en) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule : rxd_fifo
`default_nettype wire

/* core/rxd_top.sv */
// Contract
// RQ1: on a straddled beat the hit vector describes the packet starting there.
// RQ2: memory and I/O hit vector holds steady for the whole packet from start.
// RQ3: one hit bit for a 32-bit aperture, two adjacent for 64-bit.
// RQ4: hit vector means nothing for other packet kinds; user must ignore it.
// RQ5: link loss acts as hot reset; buffered packets are lost.
// RQ6: a packet mid-delivery at link loss is still completed to full length; one that began on a straddled beat behind an unforwarded packet is not.
// RQ7: user discards a packet that was in flight at link loss.
// RQ8: user reports errors in delivered packets that the block does not check.
// RQ9: endpoint answers memory/atomic/IO with UR on miss or outside D0.
// RQ10: endpoint drops aperture misses and raises UR itself.
// RQ11: endpoint consumes internal type 0 config; user-space config is delivered.
// RQ12: endpoint URs type 1 config; bad completions flagged Unexpected Completion.
// RQ13: endpoint absorbs slot power message and captures scale and value.
// RQ14: endpoint absorbs ASPM NAK and turn-off; URs PME and turn-off ack.
// RQ15: unlock ignored by non-legacy endpoint, delivered by legacy endpoint.
// RQ16: endpoint: INTx fatal, error messages UR, vendor messages delivered.
// RQ17: hot plug messages silently discarded in both roles.
// RQ18: delivered messages also indicated; root port streams them only if enabled.
// RQ19: root port has no aperture filter; UR only outside D0.
// RQ20: atomic packets are classed as non-posted memory transactions.
// RQ21: user builds and sends its own atomic requests.
// RQ22: user builds completions for atomics it receives.
// RQ23: advertised payload 128..1024 bytes; 1024 barred on x8 5.0G 128-bit.
// RQ24: host programs payload no larger than advertised capability.
// RQ25: device control contents driven continuously on a 16-bit output.
`timescale 1ns/100ps
`default_nettype none
module rxd_top #(
  parameter int         DATA_W      = rxd_pkg::DATA_W_DFLT,
  parameter int         DEPTH       = rxd_pkg::DEPTH_DFLT,
  parameter bit         ROOT_PORT   = 1'b0,
  parameter bit         LEGACY_EP   = 1'b0,
  parameter bit         RP_MSG_FWD  = 1'b0,
  parameter logic [2:0] MPS_CAP     = rxd_pkg::MPS_256,
  parameter bit         X8_G2_128   = 1'b0
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_clk_en,
  input  wire logic                       i_link_up,
  input  wire logic                       i_is_d0,
  input  wire logic                       i_rx_valid,
  output logic                            o_rx_ready,
  input  wire logic [DATA_W-1:0]          i_rx_data,
  input  wire logic                       i_start_of_packet_flag,
  input  wire logic                       i_rx_eof,
  input  wire logic                       i_rx_straddle,
  input  wire rxd_pkg::rxd_kind_e         i_tlp_kind,
  input  wire logic [rxd_pkg::BEATS_W-1:0] i_tlp_dw,
  input  wire logic                       i_bar_miss,
  input  wire logic [2:0]                 i_bar_idx,
  input  wire logic                       i_bar_is64,
  input  wire logic                       i_rid_match,
  input  wire logic                       i_cfg_internal,
  input  wire logic [9:0]                 i_msg_payload,
  input  wire logic [15:0]                i_dev_ctrl,
  output logic                            o_rx_valid,
  input  wire logic                       i_rx_user_ready,
  output logic [DATA_W-1:0]               o_rx_data,
  output logic                            o_start_of_packet_flag,
  output logic                            o_rx_eof,
  output logic [rxd_pkg::BAR_W-1:0]       o_bar_hit,
  output logic                            o_rx_nonposted,
  output logic                            o_rx_discontinue,
  output logic                            o_ur,
  output logic                            o_uc,
  output logic                            o_fatal,
  output logic                            o_cfg_consumed,
  output logic                            o_pm_asnak,
  output logic                            o_pm_turn_off,
  output logic                            o_msg_valid,
  output rxd_pkg::rxd_kind_e              o_msg_kind,
  output logic [1:0]                      o_slot_pwr_scale,
  output logic [7:0]                      o_slot_pwr_value,
  output logic [15:0]                     o_dev_ctrl,
  output logic [2:0]                      o_max_payload_cap
);
  import rxd_pkg::*;

  localparam int DWB = DATA_W / 32;
  localparam int FW  = DATA_W + 3 + BAR_W + BEATS_W;

  rxd_disp_e            disp;
  logic                 is_msg, stream_it, fwd_beat, sof_take;
  logic [BAR_W-1:0]     hit_vec;
  logic [BEATS_W-1:0]   beats;
  logic                 cur_fwd_q, cur_fwd_d;
  logic                 ur_q, ur_d, uc_q, uc_d, fat_q, fat_d;
  logic                 cfg_q, cfg_d, nak_q, nak_d, off_q, off_d;
  logic                 msg_q, msg_d;
  rxd_kind_e            mkind_q, mkind_d;
  logic [1:0]           spl_s_q, spl_s_d;
  logic [7:0]           spl_v_q, spl_v_d;
  logic [15:0]          dctl_q, dctl_d;
  logic [FW-1:0]        f_in, f_out;
  logic                 f_in_rdy, f_out_vld, f_pop;
  rxd_ostate_e          ost_q, ost_d;
  logic [BEATS_W-1:0]   rem_q, rem_d;

  // RQ3 aperture hit bits
  assign hit_vec = i_bar_is64 ? BAR_W'(8'h03 << i_bar_idx) : BAR_W'(8'h01 << i_bar_idx);
  assign beats   = BEATS_W'((i_tlp_dw + BEATS_W'(DWB - 1)) / BEATS_W'(DWB));

  always_comb begin
    disp   = D_PRESENT;
    is_msg = 1'b0;
    unique case (i_tlp_kind)
      // RQ9 RQ10 RQ19 aperture and power filter
      K_MEM, K_IO, K_ATOMIC: begin
        if (ROOT_PORT) disp = i_is_d0 ? D_PRESENT : D_UR;
        else disp = (i_bar_miss || !i_is_d0) ? D_UR : D_PRESENT;
      end
      K_MEM_LK: begin
        if (ROOT_PORT) disp = D_PRESENT;
        else if (!LEGACY_EP || i_bar_miss || !i_is_d0) disp = D_UR;
        else disp = D_PRESENT;
      end
      // RQ11 internal config consumed
      K_CFG0:  disp = ROOT_PORT ? D_UR : (i_cfg_internal ? D_CONSUME : D_PRESENT);
      // RQ12 type 1 config and completions
      K_CFG1:  disp = D_UR;
      K_CPL:   disp = (!ROOT_PORT && (!i_rid_match || !i_is_d0)) ? D_UC : D_PRESENT;
      // RQ13 slot power absorbed
      K_SSPL:  disp = ROOT_PORT ? D_UR : D_CONSUME;
      // RQ14 power management messages
      K_PME, K_TO_ACK: begin
        disp   = ROOT_PORT ? D_PRESENT : D_UR;
        is_msg = ROOT_PORT;
      end
      K_ASNAK:   disp = ROOT_PORT ? D_UR : D_CONSUME;
      K_TURNOFF: disp = ROOT_PORT ? D_FATAL : D_CONSUME;
      // RQ15 unlock by legacy setting
      K_UNLOCK: begin
        disp   = ROOT_PORT ? D_FATAL : (LEGACY_EP ? D_PRESENT : D_IGNORE);
        is_msg = !ROOT_PORT && LEGACY_EP;
      end
      // RQ16 interrupt, error and vendor messages
      K_INTX: begin
        disp   = ROOT_PORT ? D_PRESENT : D_FATAL;
        is_msg = ROOT_PORT;
      end
      K_ERRMSG: begin
        disp   = ROOT_PORT ? D_PRESENT : D_UR;
        is_msg = ROOT_PORT;
      end
      K_VDM: begin
        disp   = D_PRESENT;
        is_msg = 1'b1;
      end
      // RQ17 hot plug dropped silently
      K_HOTPLUG: disp = D_DROP;
      default:   disp = D_DROP;
    endcase
  end

  // RQ18 root port streams messages only when enabled
  assign stream_it = (disp == D_PRESENT) && !(ROOT_PORT && is_msg && !RP_MSG_FWD);
  assign sof_take  = i_rx_valid && i_start_of_packet_flag && i_link_up;
  // a straddled beat still carries the tail of a forwarded packet
  assign fwd_beat  = i_link_up && (i_start_of_packet_flag ?
                     (stream_it || (i_rx_straddle && cur_fwd_q)) : cur_fwd_q);
  // RQ5 beats are swallowed while the link is down
  assign o_rx_ready = i_clk_en && (!fwd_beat || f_in_rdy);

  // RQ1 RQ2 hit and class from the start beat decode, held by upstream
  // RQ4 zero hit for non memory or I/O kinds
  // RQ20 atomics travel as non-posted
  assign f_in = {i_rx_data, i_start_of_packet_flag && stream_it, i_rx_eof,
                 (i_tlp_kind == K_MEM || i_tlp_kind == K_IO || i_tlp_kind == K_ATOMIC ||
                  i_tlp_kind == K_MEM_LK || i_tlp_kind == K_CFG0 || i_tlp_kind == K_CFG1),
                 (i_tlp_kind == K_MEM || i_tlp_kind == K_IO || i_tlp_kind == K_ATOMIC ||
                  i_tlp_kind == K_MEM_LK) ? hit_vec : BAR_W'(0),
                 beats};

  always_comb begin
    cur_fwd_d = cur_fwd_q;
    ur_d      = 1'b0;
    uc_d      = 1'b0;
    fat_d     = 1'b0;
    cfg_d     = 1'b0;
    nak_d     = 1'b0;
    off_d     = 1'b0;
    msg_d     = 1'b0;
    mkind_d   = mkind_q;
    spl_s_d   = spl_s_q;
    spl_v_d   = spl_v_q;
    dctl_d    = i_dev_ctrl;
    if (i_rx_valid && o_rx_ready) begin
      if (i_start_of_packet_flag) cur_fwd_d = stream_it;
      else if (i_rx_eof) cur_fwd_d = 1'b0;
      if (i_rx_eof && !i_start_of_packet_flag) cur_fwd_d = 1'b0;
    end
    if (sof_take && o_rx_ready) begin
      ur_d  = (disp == D_UR);
      uc_d  = (disp == D_UC);
      fat_d = (disp == D_FATAL);
      cfg_d = (i_tlp_kind == K_CFG0) && (disp == D_CONSUME);
      nak_d = (i_tlp_kind == K_ASNAK) && (disp == D_CONSUME);
      off_d = (i_tlp_kind == K_TURNOFF) && (disp == D_CONSUME);
      msg_d = is_msg && (disp == D_PRESENT);
      if (is_msg && disp == D_PRESENT) mkind_d = i_tlp_kind;
      // RQ13 capture scale and value
      if (i_tlp_kind == K_SSPL && disp == D_CONSUME) begin
        spl_s_d = i_msg_payload[SPL_SCALE_LSB+1:SPL_SCALE_LSB];
        spl_v_d = i_msg_payload[SPL_SCALE_LSB-1:0];
      end
    end
    // RQ5 link loss forgets the packet in progress
    if (!i_link_up) cur_fwd_d = 1'b0;
  end

  rxd_fifo #(
    .W     (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_flush   (!i_link_up),
    .i_valid   (i_rx_valid && fwd_beat),
    .o_ready   (f_in_rdy),
    .i_data    (f_in),
    .o_valid   (f_out_vld),
    .i_ready   (f_pop),
    .o_data    (f_out)
  );

  assign f_pop = (ost_q != O_PAD) && i_rx_user_ready && i_link_up;

  always_comb begin
    ost_d = ost_q;
    rem_d = rem_q;
    unique case (ost_q)
      O_IDLE: begin
        if (f_pop && f_out_vld && f_out[FW-DATA_W-1]) begin
          rem_d = f_out[BEATS_W-1:0] - 1'b1;
          ost_d = f_out[FW-DATA_W-2] ? O_IDLE : O_PKT;
        end
      end
      O_PKT: begin
        // RQ6 pad out the packet when the link drops mid-transfer
        if (!i_link_up) begin
          ost_d = O_PAD;
        end else if (f_pop && f_out_vld) begin
          rem_d = rem_q - 1'b1;
          if (f_out[FW-DATA_W-1]) rem_d = f_out[BEATS_W-1:0] - 1'b1;
          if (f_out[FW-DATA_W-2] && !f_out[FW-DATA_W-1]) ost_d = O_IDLE;
        end
      end
      O_PAD: begin
        if (i_rx_user_ready) begin
          rem_d = rem_q - 1'b1;
          if (rem_q == BEATS_W'(1)) ost_d = O_IDLE;
        end
      end
    endcase
    if (ost_q != O_PAD && ost_d == O_PAD && rem_q == '0) ost_d = O_IDLE;
  end

  // no handshake while frozen, or a beat would be lost or doubled
  assign o_rx_valid = i_clk_en && ((ost_q == O_PAD) || (f_out_vld && i_link_up));
  assign o_rx_data  = (ost_q == O_PAD) ? DATA_W'(0) : f_out[FW-1 -: DATA_W];
  assign o_start_of_packet_flag = (ost_q != O_PAD) && f_out_vld && f_out[FW-DATA_W-1];
  assign o_rx_eof   = (ost_q == O_PAD) ? (rem_q == BEATS_W'(1)) : (f_out_vld && f_out[FW-DATA_W-2]);
  assign o_rx_nonposted = (ost_q != O_PAD) && f_out_vld && f_out[FW-DATA_W-3];
  assign o_bar_hit  = (ost_q == O_PAD) ? BAR_W'(0) : f_out[BEATS_W +: BAR_W];
  // RQ7 user told the padded packet is corrupt
  assign o_rx_discontinue = (ost_q == O_PAD);

  assign o_ur             = ur_q;
  assign o_uc             = uc_q;
  assign o_fatal          = fat_q;
  assign o_cfg_consumed   = cfg_q;
  assign o_pm_asnak       = nak_q;
  assign o_pm_turn_off    = off_q;
  assign o_msg_valid      = msg_q;
  assign o_msg_kind       = mkind_q;
  assign o_slot_pwr_scale = spl_s_q;
  assign o_slot_pwr_value = spl_v_q;
  // RQ25 device control mirrored
  assign o_dev_ctrl       = dctl_q;
  // RQ23 1024 bytes not offered on the wide x8 variant
  assign o_max_payload_cap = (X8_G2_128 && MPS_CAP == MPS_1024) ? MPS_512 : MPS_CAP;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cur_fwd_q <= 1'b0;
      ur_q      <= 1'b0;
      uc_q      <= 1'b0;
      fat_q     <= 1'b0;
      cfg_q     <= 1'b0;
      nak_q     <= 1'b0;
      off_q     <= 1'b0;
      msg_q     <= 1'b0;
      mkind_q   <= K_MEM;
      spl_s_q   <= SPL_SCALE_RST;
      spl_v_q   <= SPL_VALUE_RST;
      dctl_q    <= DEV_CTRL_RST;
      ost_q     <= O_IDLE;
      rem_q     <= '0;
    end else if (i_clk_en) begin
      cur_fwd_q <= cur_fwd_d;
      ur_q      <= ur_d;
      uc_q      <= uc_d;
      fat_q     <= fat_d;
      cfg_q     <= cfg_d;
      nak_q     <= nak_d;
      off_q     <= off_d;
      msg_q     <= msg_d;
      mkind_q   <= mkind_d;
      spl_s_q   <= spl_s_d;
      spl_v_q   <= spl_v_d;
      dctl_q    <= dctl_d;
      ost_q     <= ost_d;
      rem_q     <= rem_d;
    end
  end
endmodule : rxd_top
`default_nettype wire

/* sim/rxd_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rxd_top_sva
  import rxd_pkg::*;
#(
  parameter int         DATA_W  = DATA_W_DFLT,
  parameter logic [2:0] MPS_CAP = MPS_256
) (
  input wire logic              i_sys_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_clk_en,
  input wire logic              i_link_up,
  input wire logic              i_rx_valid,
  input wire logic              o_rx_ready,
  input wire logic              i_start_of_packet_flag,
  input wire rxd_kind_e         i_tlp_kind,
  input wire logic [9:0]        i_msg_payload,
  input wire logic [15:0]       i_dev_ctrl,
  input wire logic              o_rx_valid,
  input wire logic              i_rx_user_ready,
  input wire logic [DATA_W-1:0] o_rx_data,
  input wire logic              o_start_of_packet_flag,
  input wire logic              o_rx_eof,
  input wire logic [BAR_W-1:0]  o_bar_hit,
  input wire logic              o_rx_discontinue,
  input wire logic              o_ur,
  input wire logic              o_uc,
  input wire logic              o_fatal,
  input wire logic              o_msg_valid,
  input wire logic [1:0]        o_slot_pwr_scale,
  input wire logic [7:0]        o_slot_pwr_value,
  input wire logic [15:0]       o_dev_ctrl,
  input wire logic [2:0]        o_max_payload_cap
);
  logic             take_sof;
  logic             out_beat;
  logic             in_pkt_d;
  logic             in_pkt_q;
  logic [BAR_W-1:0] hit_d;
  logic [BAR_W-1:0] hit_q;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  assign take_sof = i_rx_valid && o_rx_ready && i_start_of_packet_flag;
  assign out_beat = o_rx_valid && i_rx_user_ready;

  // a straddled start leaves in_pkt low, so its later beats go unchecked
  always_comb begin
    in_pkt_d = in_pkt_q;
    hit_d    = hit_q;
    if (out_beat && o_rx_eof) in_pkt_d = 1'b0;
    if (out_beat && o_start_of_packet_flag) begin
      hit_d    = o_bar_hit;
      in_pkt_d = !o_rx_eof;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      in_pkt_q <= 1'b0;
      hit_q    <= '0;
    end else begin
      in_pkt_q <= in_pkt_d;
      hit_q    <= hit_d;
    end
  end

  chk_ur_cause: assert property (o_ur |-> $past(take_sof))
    else $error("ur pulse without a start beat");
  chk_uc_cause: assert property (o_uc |-> $past(take_sof && i_tlp_kind == K_CPL))
    else $error("uc pulse without a completion");
  chk_fatal_cause: assert property (o_fatal |-> $past(take_sof && i_tlp_kind == K_INTX))
    else $error("fatal pulse without an intx message");
  chk_hotplug_quiet: assert property (take_sof && i_tlp_kind == K_HOTPLUG |=> !(o_ur || o_uc || o_fatal || o_msg_valid))
    else $error("hot plug message was reported");
  chk_slot_load: assert property (take_sof && i_link_up && i_tlp_kind == K_SSPL |=>
    {o_slot_pwr_scale, o_slot_pwr_value} == $past(i_msg_payload))
    else $error("slot power fields not captured");
  chk_hit_shape: assert property (out_beat && o_start_of_packet_flag && o_bar_hit != '0 |->
    $onehot(o_bar_hit) || ($countones(o_bar_hit) == 2 && (o_bar_hit & (o_bar_hit << 1)) != '0))
    else $error("hit vector neither one bit nor two adjacent");
  chk_hit_stable: assert property (o_rx_valid && in_pkt_q && !o_start_of_packet_flag && !o_rx_discontinue |->
    o_bar_hit == hit_q)
    else $error("hit vector changed inside a packet");
  chk_pad_zero: assert property (o_rx_discontinue |-> o_rx_valid && o_rx_data == '0)
    else $error("pad beat not valid or not zero");
  chk_dev_copy: assert property (!$past(i_sys_rst) && $past(i_clk_en) |-> o_dev_ctrl == $past(i_dev_ctrl))
    else $error("device control copy wrong");
  chk_cap_const: assert property (o_max_payload_cap == MPS_CAP)
    else $error("payload capability code wrong");
endmodule : rxd_top_sva
bind rxd_top rxd_top_sva #(.DATA_W(DATA_W), .MPS_CAP(MPS_CAP)) rxd_top_sva_inst (.*);
`default_nettype wire

/* sim/rxd_user_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rxd_user_model #(
  parameter int DATA_W = 64
) (
  input  wire logic              i_sys_clk,
  input  wire logic [1:0]        i_mode,
  input  wire logic              i_valid,
  input  wire logic              i_sof,
  input  wire logic              i_eof,
  input  wire logic              i_disc,
  input  wire logic              i_np,
  input  wire logic [7:0]        i_hit,
  input  wire logic [DATA_W-1:0] i_data,
  output logic                   o_ready
);
  logic [DATA_W-1:0] q[$];
  int                n_sof = 0;
  int                n_beat = 0;
  int                n_disc = 0;
  logic [7:0]        last_hit;
  logic              last_np;
  logic              last_eof;
  logic              corrupt = 1'b0;

  initial o_ready = 1'b0;
  always @(posedge i_sys_clk) begin
    if (i_valid && o_ready) begin
      n_beat++;
      last_eof = i_eof;
      if (i_sof) begin
        n_sof++;
        q.push_back(i_data);
        last_hit = i_hit;
        last_np  = i_np;
        corrupt  = 1'b0;
      end
      if (i_disc) begin
        n_disc++;
        if (!corrupt) void'(q.pop_back());
        corrupt = 1'b1;
      end
    end
    // mode 0 prompt, 1 random stalls, 2 full stall
    #1 o_ready = (i_mode == 2'h0) || ((i_mode == 2'h1) && ($urandom_range(1) == 1));
  end
endmodule : rxd_user_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rxd_pkg::*;
  logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1, i_link_up = 1'b1, i_is_d0 = 1'b1;
  logic i_rx_valid = 1'b0, i_start_of_packet_flag = 1'b0, i_rx_eof = 1'b0, i_rx_straddle = 1'b0;
  logic i_bar_miss = 1'b0, i_bar_is64 = 1'b0, i_rid_match = 1'b1, i_cfg_internal = 1'b0, i_rx_user_ready;
  rxd_kind_e          i_tlp_kind = K_MEM;
  logic [BEATS_W-1:0] i_tlp_dw = 11'h000;
  logic [2:0]         i_bar_idx = 3'h0;
  logic [9:0]         i_msg_payload = 10'h000;
  logic [15:0]        i_dev_ctrl = 16'h0000;
  logic [63:0]        i_rx_data = 64'h0;
  logic o_rx_ready, o_rx_valid, o_start_of_packet_flag, o_rx_eof, o_rx_nonposted, o_rx_discontinue;
  logic o_ur, o_uc, o_fatal, o_cfg_consumed, o_pm_asnak, o_pm_turn_off, o_msg_valid;
  logic [63:0]        o_rx_data;
  logic [7:0]         o_bar_hit;
  rxd_kind_e          o_msg_kind;
  logic [1:0]         o_slot_pwr_scale;
  logic [7:0]         o_slot_pwr_value;
  logic [15:0]        o_dev_ctrl;
  logic [2:0]         o_max_payload_cap;
  logic [1:0]         mode = 2'h0;
  // payload field position in device control
  localparam int      MPS_LSB = 5;
  logic [63:0]        exp_q[$];
  logic [63:0]        fd;
  logic [7:0]         ev, e, m, hx;
  logic [3:0]         r;
  int                 n_errors = 0, checked = 0, n0, nd, nb;

  always #12.5 i_sys_clk = ~i_sys_clk;

  rxd_top rxd_top_inst (.*);
  rxd_user_model rxd_user_model_inst (.i_sys_clk(i_sys_clk), .i_mode(mode), .i_valid(o_rx_valid),
    .i_sof(o_start_of_packet_flag), .i_eof(o_rx_eof), .i_disc(o_rx_discontinue), .i_np(o_rx_nonposted),
    .i_hit(o_bar_hit), .i_data(o_rx_data), .o_ready(i_rx_user_ready));

  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic final_report;
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // bits: consumed, present, ur, uc, fatal, asnak, turn-off, msg indicated
  function automatic logic [7:0] exp_ev(rxd_kind_e k, logic ms, logic d, logic rm, logic ci);
    case (k)
      K_MEM, K_IO, K_ATOMIC: return (ms || !d) ? 8'h20 : 8'h40;
      K_MEM_LK, K_CFG1, K_PME, K_TO_ACK, K_ERRMSG: return 8'h20;
      K_CFG0: return ci ? 8'h80 : 8'h40;
      K_CPL: return (!rm || !d) ? 8'h10 : 8'h40;
      K_ASNAK: return 8'h04;
      K_TURNOFF: return 8'h02;
      K_INTX: return 8'h08;
      K_VDM: return 8'h41;
      default: return 8'h00;
    endcase
  endfunction : exp_ev

  task automatic send(input int nbt, input int dw, input logic st, input logic op);
    logic rdy;
    int   w;
    for (int b = 0; b < nbt; b++) begin
      i_rx_valid = 1'b1;
      i_start_of_packet_flag = (b == 0);
      i_rx_straddle = (b == 0) && st;
      i_rx_eof = ((b == nbt - 1) && !op) || ((b == 0) && st);
      i_tlp_dw = 11'(dw);
      i_rx_data = {$urandom, $urandom};
      if (b == 0) fd = i_rx_data;
      w = 0;
      do begin
        @(negedge i_sys_clk);
        rdy = o_rx_ready;
        @(posedge i_sys_clk);
        #1;
        w++;
      end while (!rdy && w < 200);
      if (!rdy) chk(1'b1, 1'b0);
      if (b == 0) ev = {o_cfg_consumed, 1'b0, o_ur, o_uc, o_fatal, o_pm_asnak, o_pm_turn_off, o_msg_valid};
    end
    i_rx_valid = 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask : send

  initial begin
    #1000000;
    n_errors++;
    final_report();
  end

  initial begin
    void'($urandom(32'h5BD1A0A9));
    repeat (6) @(posedge i_sys_clk);
    #1 i_sys_rst = 1'b0;
    // every kind once with clean conditions, then random mixes
    for (int i = 0; i < 170; i++) begin
      r = (i < 17) ? 4'h0 : 4'($urandom);
      i_tlp_kind = (i < 17) ? rxd_kind_e'(5'(i)) : rxd_kind_e'(5'($urandom_range(16)));
      {i_bar_miss, i_is_d0, i_rid_match, i_cfg_internal} = {r[0], !r[1], !r[2], r[3]};
      i_bar_idx = 3'($urandom_range(5));
      i_bar_is64 = (i_tlp_kind == K_MEM) && ($urandom_range(1) == 1);
      i_msg_payload = 10'($urandom);
      i_dev_ctrl = 16'($urandom);
      i_dev_ctrl[MPS_LSB +: 3] = 3'($urandom_range(int'(MPS_256)));
      mode = 2'($urandom_range(1));
      hx = i_bar_is64 ? (8'h03 << i_bar_idx) : (8'h01 << i_bar_idx);
      e = exp_ev(i_tlp_kind, i_bar_miss, i_is_d0, i_rid_match, i_cfg_internal);
      m = (i_tlp_kind inside {K_CFG0, K_CFG1}) ? 8'hBF : 8'h3F;
      n0 = rxd_user_model_inst.n_sof;
      nb = $urandom_range(3, 1);
      send(nb, nb * 2, 1'b0, 1'b0);
      if (e[6]) exp_q.push_back(fd);
      chk(ev & m, e & m);
      repeat (40) @(posedge i_sys_clk);
      #1;
      chk(rxd_user_model_inst.n_sof - n0, e[6]);
      if (e[6] && i_tlp_kind inside {K_MEM, K_IO}) chk(rxd_user_model_inst.last_hit, hx);
      if (e[6]) chk(rxd_user_model_inst.last_np, i_tlp_kind inside {K_MEM, K_IO, K_ATOMIC, K_MEM_LK, K_CFG0, K_CFG1});
      if (i_tlp_kind == K_SSPL) chk({o_slot_pwr_scale, o_slot_pwr_value}, i_msg_payload);
      if (e[0]) chk(o_msg_kind, i_tlp_kind);
      chk(o_dev_ctrl, i_dev_ctrl);
    end
    // straddled beat: hit vector belongs to the new packet
    {mode, i_tlp_kind, i_bar_miss, i_is_d0, i_bar_is64, i_bar_idx} = {2'h0, K_MEM, 1'b0, 1'b1, 1'b0, 3'h1};
    send(2, 4, 1'b0, 1'b1);
    exp_q.push_back(fd);
    i_bar_idx = 3'h3;
    send(2, 4, 1'b1, 1'b0);
    exp_q.push_back(fd);
    repeat (8) @(posedge i_sys_clk);
    #1;
    chk(rxd_user_model_inst.last_hit, 8'h08);
    // fill the buffer against a stalled user, then drain slowly
    n0 = rxd_user_model_inst.n_sof;
    mode = 2'h2;
    fork
      for (int j = 0; j < 20; j++) begin
        send(1, 2, 1'b0, 1'b0);
        exp_q.push_back(fd);
      end
      begin
        repeat (60) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk(o_rx_ready, 1'b0);
        mode = 2'h1;
      end
    join
    repeat (100) @(posedge i_sys_clk);
    #1;
    chk(rxd_user_model_inst.n_sof - n0, 20);
    // link loss in mid-packet: four beats owed, three of them padding
    mode = 2'h0;
    n0 = rxd_user_model_inst.n_beat;
    nd = rxd_user_model_inst.n_disc;
    send(1, 8, 1'b0, 1'b1);
    repeat (2) @(posedge i_sys_clk);
    #1 i_link_up = 1'b0;
    repeat (12) @(posedge i_sys_clk);
    #1;
    chk(rxd_user_model_inst.n_beat - n0, 4);
    chk(rxd_user_model_inst.n_disc - nd, 3);
    chk(rxd_user_model_inst.last_eof, 1'b1);
    i_link_up = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk(rxd_user_model_inst.q.size(), exp_q.size());
    foreach (exp_q[j]) if (j < rxd_user_model_inst.q.size()) chk(rxd_user_model_inst.q[j], exp_q[j]);
    chk(o_max_payload_cap, MPS_256);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
